//--- design/controller_fault_supervisor.sv
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
// Behaviour
// - Fatal error enters stop, lights fault and stop, forces outputs off.
// - Fatal stop persists until a restart occurs.
// - Restart clears fatal, reruns diagnostics; fault found again relights fault.
// - Restart on reset, switch run/term to stop, or host restart command.
// - Last fatal code kept while RAM retained; cleared by memory clear.
// - Fatal count kept while RAM retained; cleared by memory clear or RAM loss.
// - Non-fatal error keeps the mode, logs an event, program continues.
// - Compile violation during download aborts it, records code, keeps old program.
// - Module configuration captured at startup, compared periodically, mismatch flagged.
// - Mismatching module is neither read nor written until it matches again.
// - Global I/O error flag stands while any module reports an error.
// - Run-time fault flag set on a run-time fault, held while in run.
module controller_fault_supervisor #(
	parameter int unsigned CHECK_CYC = fault_pkg::CHECK_CYC_DEF
) (
	// Clock and reset
	input  wire logic                                       core_clk_in,
	input  wire logic                                       rst_n_in,
	// Register port
	input  wire logic [7:0]                                 reg_addr_in,
	input  wire logic [31:0]                                reg_wdata_in,
	input  wire logic                                       reg_wr_in,
	input  wire logic                                       reg_rd_in,
	output logic      [31:0]                                reg_rdata_out,
	// Mode switch and RAM retention pins
	input  wire logic [1:0]                                 mode_sw_in,
	input  wire logic                                       ram_retained_in,
	// Fault sources
	input  wire logic                                       fatal_detect_in,
	input  wire logic [fault_pkg::CODEW-1:0]                fatal_code_in,
	input  wire logic                                       rt_fault_in,
	// Download compiler
	input  wire fault_pkg::dl_req_t                         dl_in,
	output logic                                            dl_abort_out,
	output logic                                            dl_commit_out,
	// Expansion modules
	input  wire logic [fault_pkg::NMOD*fault_pkg::CFGW-1:0] mod_cfg_in,
	output logic      [fault_pkg::NMOD-1:0]                 mod_access_out,
	// Output image
	input  wire logic [fault_pkg::IMGW-1:0]                 out_image_in,
	output logic      [fault_pkg::IMGW-1:0]                 outputs_out,
	// Indicators and flags
	output fault_pkg::ind_t                                 ind_out,
	output logic                                            global_io_error_flag_out,
	output logic                                            runtime_fault_flag_out,
	output logic                                            irq_out
);

	// ==========================================
	// Declarations
	fault_pkg::mode_t            state;
	fault_pkg::mode_t            next_state;
	logic [8:0]                  diag_cnt;
	logic [8:0]                  next_diag_cnt;
	logic [15:0]                 tick_cnt;
	logic [15:0]                 next_tick_cnt;
	logic [2:0]                  boot_cnt;
	logic [2:0]                  next_boot_cnt;
	logic [1:0]                  sw;
	logic [1:0]                  sw_prev;
	logic                        ram_ok;
	logic                        capture;
	logic                        next_capture;
	logic                        tick;
	logic                        host_run;
	logic                        next_host_run;
	logic [fault_pkg::EVW-1:0]   mask;
	logic [fault_pkg::EVW-1:0]   next_mask;
	logic [fault_pkg::EVW-1:0]   events;
	logic [fault_pkg::EVW-1:0]   next_events;
	logic [fault_pkg::EVW-1:0]   ev_set;
	logic [fault_pkg::CODEW-1:0] dl_err;
	logic [fault_pkg::CODEW-1:0] next_dl_err;
	logic                        dl_aborted;
	logic                        next_dl_aborted;
	logic                        next_abort;
	logic                        next_commit;
	logic                        next_rt_flag;
	logic                        next_io_flag;
	logic [31:0]                 next_rdata;
	logic [fault_pkg::CODEW-1:0] last_fatal;
	logic [fault_pkg::CODEW-1:0] next_last_fatal;
	logic [fault_pkg::CNTW-1:0]  fatal_count;
	logic [fault_pkg::CNTW-1:0]  next_fatal_count;
	logic [fault_pkg::NMOD-1:0]  cfg_err;
	logic                        wr_ctrl;
	logic                        host_restart;
	logic                        mem_clear;
	logic                        ram_lost;
	logic                        sw_stop_edge;
	logic                        restart_req;
	logic                        run_req;
	logic                        fatal_entry;

	// ==========================================
	// Pin synchronisers and expansion checker
	sync3 #(
		.W (2)
	) u_sw_sync (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.d_in        (mode_sw_in),
		.q_out       (sw)
	);

	sync3 #(
		.W (1)
	) u_ram_sync (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.d_in        (ram_retained_in),
		.q_out       (ram_ok)
	);

	io_config_checker u_checker (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.capture_in  (capture),
		.tick_in     (tick),
		.cfg_in      (mod_cfg_in),
		.cfg_err_out (cfg_err),
		.access_out  (mod_access_out)
	);

	// ==========================================
	// Restart sources
	always_comb begin
		wr_ctrl      = reg_wr_in && (reg_addr_in == fault_pkg::REG_CTRL);
		host_restart = wr_ctrl && reg_wdata_in[fault_pkg::CTRL_RESTART];
		mem_clear    = wr_ctrl && reg_wdata_in[fault_pkg::CTRL_MEMCLR];
		sw_stop_edge = (sw_prev != fault_pkg::SW_STOP) && (sw == fault_pkg::SW_STOP);
		restart_req  = host_restart || sw_stop_edge;
		run_req      = (sw == fault_pkg::SW_RUN) || ((sw == fault_pkg::SW_TERM) && host_run);
		fatal_entry  = fatal_detect_in && (state != fault_pkg::ST_FATAL);
		ram_lost     = (boot_cnt == 3'(fault_pkg::BOOT_CYC - 1)) && !ram_ok;
		tick         = (tick_cnt == 16'(CHECK_CYC - 1));
	end

	// ==========================================
	// Mode machine
	always_comb begin
		next_state = state;
		case (state)
			fault_pkg::ST_DIAG: begin
				if (diag_cnt == 9'(fault_pkg::DIAG_CYC - 1)) begin
					next_state = run_req ? fault_pkg::ST_RUN : fault_pkg::ST_STOP;
				end
			end
			fault_pkg::ST_STOP: begin
				if (run_req) begin
					next_state = fault_pkg::ST_RUN;
				end
			end
			fault_pkg::ST_RUN: begin
				if (!run_req) begin
					next_state = fault_pkg::ST_STOP;
				end
			end
			fault_pkg::ST_FATAL: begin
				next_state = fault_pkg::ST_FATAL;
			end
			default: begin
				next_state = fault_pkg::ST_DIAG;
			end
		endcase
		if (restart_req) begin
			next_state = fault_pkg::ST_DIAG;
		end
		if (fatal_detect_in) begin
			next_state = fault_pkg::ST_FATAL;
		end
		next_diag_cnt = (state == fault_pkg::ST_DIAG && next_state == fault_pkg::ST_DIAG && !restart_req)
			? diag_cnt + 9'h001 : 9'h000;
		next_capture  = (state == fault_pkg::ST_DIAG) && (next_state != fault_pkg::ST_DIAG)
			&& (next_state != fault_pkg::ST_FATAL);
		next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
		next_boot_cnt = (boot_cnt == 3'(fault_pkg::BOOT_CYC)) ? boot_cnt : boot_cnt + 3'h1;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state    <= fault_pkg::ST_DIAG;
			diag_cnt <= 9'h000;
			capture  <= 1'b0;
			tick_cnt <= 16'h0000;
			boot_cnt <= 3'h0;
			sw_prev  <= fault_pkg::SW_STOP;
		end else begin
			state    <= next_state;
			diag_cnt <= next_diag_cnt;
			capture  <= next_capture;
			tick_cnt <= next_tick_cnt;
			boot_cnt <= next_boot_cnt;
			sw_prev  <= sw;
		end
	end

	// ==========================================
	// Retained fatal record, kept through resets while RAM is retained
	always_comb begin
		next_last_fatal  = last_fatal;
		next_fatal_count = fatal_count;
		if (mem_clear || ram_lost) begin
			next_last_fatal  = '0;
			next_fatal_count = '0;
		end else if (fatal_entry) begin
			next_last_fatal = fatal_code_in;
			if (fatal_count != '1) begin
				next_fatal_count = fatal_count + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		last_fatal  <= next_last_fatal;
		fatal_count <= next_fatal_count;
	end

	// ==========================================
	// Non-fatal flags, download checks, outputs
	always_comb begin
		next_rt_flag = (next_state == fault_pkg::ST_RUN)
			&& (runtime_fault_flag_out || rt_fault_in);
		next_io_flag = |cfg_err;
		next_abort   = dl_in.active && dl_in.violation && !dl_aborted;
		next_commit  = dl_in.done && !dl_aborted && !next_abort;
		next_dl_err  = next_abort ? dl_in.code : dl_err;
		next_dl_aborted = dl_in.done ? 1'b0 : (dl_aborted || next_abort);
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			runtime_fault_flag_out   <= 1'b0;
			global_io_error_flag_out <= 1'b0;
			dl_abort_out             <= 1'b0;
			dl_commit_out            <= 1'b0;
			dl_err                   <= fault_pkg::DLERR_RST;
			dl_aborted               <= 1'b0;
			ind_out                  <= '{fault: 1'b0, stop: 1'b1, run: 1'b0};
			outputs_out              <= '0;
		end else begin
			runtime_fault_flag_out   <= next_rt_flag;
			global_io_error_flag_out <= next_io_flag;
			dl_abort_out             <= next_abort;
			dl_commit_out            <= next_commit;
			dl_err                   <= next_dl_err;
			dl_aborted               <= next_dl_aborted;
			ind_out.fault            <= (next_state == fault_pkg::ST_FATAL);
			ind_out.stop             <= (next_state != fault_pkg::ST_RUN);
			ind_out.run              <= (next_state == fault_pkg::ST_RUN);
			outputs_out              <= (next_state == fault_pkg::ST_RUN) ? out_image_in : '0;
		end
	end

	// ==========================================
	// Register port, events and interrupt
	always_comb begin
		ev_set = '0;
		ev_set[fault_pkg::EV_FATAL] = fatal_entry;
		ev_set[fault_pkg::EV_IO]    = next_io_flag && !global_io_error_flag_out;
		ev_set[fault_pkg::EV_RT]    = rt_fault_in && (state == fault_pkg::ST_RUN);
		ev_set[fault_pkg::EV_DL]    = next_abort;
		next_events = events | ev_set;
		if (reg_rd_in && reg_addr_in == fault_pkg::REG_EVENT) begin
			next_events = ev_set;
		end
		next_host_run = host_run;
		next_mask     = mask;
		if (wr_ctrl) begin
			next_host_run = reg_wdata_in[fault_pkg::CTRL_HOST_RUN];
		end
		if (reg_wr_in && reg_addr_in == fault_pkg::REG_MASK) begin
			next_mask = reg_wdata_in[fault_pkg::EVW-1:0];
		end
		next_rdata = 32'h0000_0000;
		if (reg_rd_in) begin
			case (reg_addr_in)
				fault_pkg::REG_CTRL:   next_rdata = {31'h0, host_run};
				fault_pkg::REG_STATUS: next_rdata = {28'h0, runtime_fault_flag_out,
					global_io_error_flag_out, state};
				fault_pkg::REG_LAST:   next_rdata = {24'h0, last_fatal};
				fault_pkg::REG_COUNT:  next_rdata = {16'h0, fatal_count};
				fault_pkg::REG_DLERR:  next_rdata = {24'h0, dl_err};
				fault_pkg::REG_IOERR:  next_rdata = {28'h0, cfg_err};
				fault_pkg::REG_EVENT:  next_rdata = {28'h0, events};
				fault_pkg::REG_MASK:   next_rdata = {28'h0, mask};
				default:               next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			host_run      <= 1'b0;
			mask          <= fault_pkg::MASK_RST;
			events        <= '0;
			reg_rdata_out <= 32'h0000_0000;
			irq_out       <= 1'b0;
		end else begin
			host_run      <= next_host_run;
			mask          <= next_mask;
			events        <= next_events;
			reg_rdata_out <= next_rdata;
			irq_out       <= |(next_events & next_mask);
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence restart_from_fatal;
		state == fault_pkg::ST_FATAL && restart_req && !fatal_detect_in;
	endsequence

	sequence diag_clean;
		state == fault_pkg::ST_DIAG && !ind_out.fault && ind_out.stop;
	endsequence

	chk_fatal_safe_state: assert property (fatal_detect_in |=>
		state == fault_pkg::ST_FATAL && ind_out.fault && ind_out.stop && outputs_out == '0)
		else $error("fatal error did not reach safe stop");
	chk_fatal_hold: assert property (state == fault_pkg::ST_FATAL && !restart_req |=>
		state == fault_pkg::ST_FATAL) else $error("fatal stop left without restart");
	chk_restart_clears: assert property (restart_from_fatal |=> diag_clean)
		else $error("restart did not clear fatal state");
	chk_switch_restart: assert property ($changed(sw) && sw == fault_pkg::SW_STOP
		&& $past(sw) != fault_pkg::SW_STOP && !fatal_detect_in |=> state == fault_pkg::ST_DIAG)
		else $error("switch to stop did not restart");
	chk_last_code: assert property (fatal_entry && !mem_clear && !ram_lost |=>
		last_fatal == $past(fatal_code_in)) else $error("last fatal code not stored");
	chk_count_step: assert property (fatal_entry && !mem_clear && !ram_lost && fatal_count != '1
		|=> fatal_count == $past(fatal_count) + 16'h0001) else $error("fatal count not advanced");
	chk_nonfatal_mode: assert property (state == fault_pkg::ST_RUN && rt_fault_in
		&& !fatal_detect_in && !restart_req && run_req |=> state == fault_pkg::ST_RUN && events[fault_pkg::EV_RT])
		else $error("non-fatal error changed the mode");
	chk_dl_abort: assert property (next_abort |=> dl_abort_out && !dl_commit_out
		##1 !dl_commit_out) else $error("compile violation did not abort download");
	chk_io_flag: assert property (|cfg_err |=> global_io_error_flag_out)
		else $error("global I/O flag missing");
	chk_access_block: assert property (##1 (mod_access_out & cfg_err) == '0)
		else $error("access to mismatching module");
	chk_rt_hold: assert property (runtime_fault_flag_out && state == fault_pkg::ST_RUN
		&& $past(state) == fault_pkg::ST_RUN ##1 state == fault_pkg::ST_RUN |-> runtime_fault_flag_out)
		else $error("run-time flag dropped in run");
	chk_rt_clear: assert property (state != fault_pkg::ST_RUN |-> !runtime_fault_flag_out)
		else $error("run-time flag kept outside run");

endmodule

//--- design/fault_pkg.sv
package fault_pkg;

	// ==========================================
	// Sizes
	localparam int NMOD  = 4;
	localparam int CFGW  = 8;
	localparam int CODEW = 8;
	localparam int CNTW  = 16;
	localparam int EVW   = 4;
	localparam int IMGW  = 8;

	// ==========================================
	// Register offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LAST   = 8'h08;
	localparam logic [7:0] REG_COUNT  = 8'h0C;
	localparam logic [7:0] REG_DLERR  = 8'h10;
	localparam logic [7:0] REG_IOERR  = 8'h14;
	localparam logic [7:0] REG_EVENT  = 8'h18;
	localparam logic [7:0] REG_MASK   = 8'h1C;

	// ==========================================
	// Field positions
	localparam int CTRL_HOST_RUN = 0;
	localparam int CTRL_RESTART  = 1;
	localparam int CTRL_MEMCLR   = 2;
	localparam int EV_FATAL      = 0;
	localparam int EV_IO         = 1;
	localparam int EV_RT         = 2;
	localparam int EV_DL         = 3;

	// ==========================================
	// Reset values
	localparam logic [EVW-1:0]   MASK_RST  = 4'h0;
	localparam logic [CODEW-1:0] DLERR_RST = 8'h00;

	// ==========================================
	// Timing
	localparam int CLK_MHZ       = 40;
	localparam int DIAG_TIME_NS  = 10000;
	localparam int DIAG_CYC      = (DIAG_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CHECK_TIME_US = 1000;
	localparam int CHECK_CYC_DEF = CHECK_TIME_US * CLK_MHZ;
	localparam int BOOT_CYC      = 6;

	// ==========================================
	// Mode switch positions and controller modes
	localparam logic [1:0] SW_STOP = 2'h0;
	localparam logic [1:0] SW_RUN  = 2'h1;
	localparam logic [1:0] SW_TERM = 2'h2;

	typedef enum logic [1:0] {
		ST_DIAG  = 2'h0,
		ST_STOP  = 2'h1,
		ST_RUN   = 2'h3,
		ST_FATAL = 2'h2
	} mode_t;

	typedef struct packed {
		logic             active;
		logic             violation;
		logic             done;
		logic [CODEW-1:0] code;
	} dl_req_t;

	typedef struct packed {
		logic fault;
		logic stop;
		logic run;
	} ind_t;

endpackage

//--- design/io_config_checker.sv
`timescale 1ns/10ps
module io_config_checker (
	// Clock and reset
	input  wire logic                                        core_clk_in,
	input  wire logic                                        rst_n_in,
	// Control
	input  wire logic                                        capture_in,
	input  wire logic                                        tick_in,
	input  wire logic [fault_pkg::NMOD*fault_pkg::CFGW-1:0]  cfg_in,
	// Results
	output logic      [fault_pkg::NMOD-1:0]                  cfg_err_out,
	output logic      [fault_pkg::NMOD-1:0]                  access_out
);

	logic [fault_pkg::CFGW-1:0] snap      [fault_pkg::NMOD];
	logic [fault_pkg::CFGW-1:0] next_snap [fault_pkg::NMOD];
	logic [fault_pkg::NMOD-1:0] next_err;
	logic [fault_pkg::NMOD-1:0] next_access;
	logic                       armed;
	logic                       next_armed;

	function automatic logic [fault_pkg::CFGW-1:0] slice(
		input logic [fault_pkg::NMOD*fault_pkg::CFGW-1:0] v,
		input int i
	);
		slice = v[i*fault_pkg::CFGW +: fault_pkg::CFGW];
	endfunction

	// ==========================================
	// Capture at startup, compare on each tick
	// Nothing is compared before the first capture: an empty snapshot would flag every module
	always_comb begin
		next_err   = cfg_err_out;
		next_armed = armed || capture_in;
		for (int i = 0; i < fault_pkg::NMOD; i++) begin
			next_snap[i] = capture_in ? slice(cfg_in, i) : snap[i];
			if (capture_in) begin
				next_err[i] = 1'b0;
			end else if (tick_in && armed) begin
				next_err[i] = (slice(cfg_in, i) != snap[i]);
			end
		end
		next_access = next_armed ? ~next_err : '0;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < fault_pkg::NMOD; i++) begin
				snap[i] <= '0;
			end
			cfg_err_out <= '0;
			access_out  <= '0;
			armed       <= 1'b0;
		end else begin
			snap        <= next_snap;
			cfg_err_out <= next_err;
			access_out  <= next_access;
			armed       <= next_armed;
		end
	end

endmodule

//--- design/sync3.sv
`timescale 1ns/10ps
module sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk_in,
	input  wire logic         rst_n_in,
	// Data
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// New value taken only once the second and third stages agree
	always_comb begin
		next_q = (s2 == s3) ? s3 : q_out;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1    <= '0;
			s2    <= '0;
			s3    <= '0;
			q_out <= '0;
		end else begin
			s1    <= d_in;
			s2    <= s1;
			s3    <= s2;
			q_out <= next_q;
		end
	end

endmodule

//--- test/controller_fault_supervisor_tb.sv
`timescale 1ns/10ps
module controller_fault_supervisor_tb;
	// ==========================================
	// Signals
	logic               core_clk_in = 1'b0;
	logic               rst_n_in = 1'b0;
	logic [7:0]         reg_addr_in = 8'h00;
	logic [31:0]        reg_wdata_in = 32'h0;
	logic               reg_wr_in = 1'b0;
	logic               reg_rd_in = 1'b0;
	logic [31:0]        reg_rdata_out;
	logic [1:0]         mode_sw_in = fault_pkg::SW_RUN;
	logic               ram_retained_in = 1'b0;
	logic               fatal_detect_in = 1'b0;
	logic               rt_fault_in = 1'b0;
	logic               bad = 1'b0;
	logic [7:0]         fatal_code_in = 8'h00;
	logic [7:0]         out_image_in = 8'h00;
	logic [7:0]         rnd = 8'h24;
	logic [7:0]         code;
	fault_pkg::dl_req_t dl_in = '0;
	logic               dl_abort_out;
	logic               dl_commit_out;
	logic               global_io_error_flag_out;
	logic               runtime_fault_flag_out;
	logic               irq_out;
	logic [31:0]        mod_cfg_in;
	logic [3:0]         mod_access_out;
	logic [7:0]         outputs_out;
	fault_pkg::ind_t    ind_out;
	logic [31:0]        exp_q[$];
	logic               rd_d = 1'b0;
	int                 fails = 0;
	int                 compares = 0;

	always #12.5 core_clk_in = ~core_clk_in;

	controller_fault_supervisor #(.CHECK_CYC(16)) dut (
		.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
		.mode_sw_in, .ram_retained_in, .fatal_detect_in, .fatal_code_in, .rt_fault_in, .dl_in,
		.dl_abort_out, .dl_commit_out, .mod_cfg_in, .mod_access_out, .out_image_in, .outputs_out,
		.ind_out, .global_io_error_flag_out, .runtime_fault_flag_out, .irq_out
	);

	io_modules_model modules (.sel_in(2'h2), .bad_in(bad), .cfg_out(mod_cfg_in));

	// ==========================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	function automatic logic probe(input int s);
		case (s)
			0: return ind_out.run;
			1: return ~mod_access_out[2];
			2: return mod_access_out[2];
			default: return ~ind_out.run;
		endcase
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask

	task automatic wait_for(input int s, input int lim);
		int n;
		n = 0;
		while (probe(s) !== 1'b1) begin
			if (n == lim) begin
				fails++;
				$display("wrong value at %0t: wait %0d timed out", $time, s);
				summarize();
			end
			n++;
			cyc(1);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		cyc(1);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge core_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		cyc(1);
	endtask

	task automatic dl(input logic x, input logic d);
		dl_in <= {1'b1, x, d, rnd};
		cyc(1);
		dl_in <= '0;
	endtask

	// Read data is compared one cycle after the strobe
	always @(posedge core_clk_in) begin
		if (rd_d) begin
			check(reg_rdata_out, exp_q.pop_front());
		end
		rd_d <= reg_rd_in;
	end

	// ==========================================
	// Scenarios
	initial begin
		cyc(16);
		rst_n_in <= 1'b1;
		cyc(10);
		rd(fault_pkg::REG_LAST, 32'h0);
		rd(fault_pkg::REG_COUNT, 32'h0);
		rd(fault_pkg::REG_MASK, 32'(fault_pkg::MASK_RST));
		rd(fault_pkg::REG_DLERR, 32'(fault_pkg::DLERR_RST));
		rd(8'h20, 32'h0);
		wait_for(0, 500);
		cyc(3);
		check(32'(mod_access_out), 32'hF);
		rnd = lfsr(rnd);
		out_image_in <= rnd;
		cyc(2);
		check(32'(outputs_out), 32'(rnd));
		wr(fault_pkg::REG_MASK, 32'hD);
		rt_fault_in <= 1'b1;
		cyc(1);
		rt_fault_in <= 1'b0;
		cyc(3);
		check(32'(runtime_fault_flag_out), 32'h1);
		check(32'(irq_out), 32'h1);
		rd(fault_pkg::REG_STATUS, 32'hB);
		rd(fault_pkg::REG_EVENT, 32'h4);
		cyc(2);
		check(32'(irq_out), 32'h0);
		rnd = lfsr(rnd);
		dl(1'b1, 1'b0);
		check(32'(dl_abort_out), 32'h1);
		cyc(1);
		check(32'(dl_abort_out), 32'h0);
		dl(1'b0, 1'b1);
		check(32'(dl_commit_out), 32'h0);
		rd(fault_pkg::REG_DLERR, 32'(rnd));
		check(32'(irq_out), 32'h1);
		rd(fault_pkg::REG_EVENT, 32'h8);
		dl(1'b0, 1'b1);
		check(32'(dl_commit_out), 32'h1);
		rd(fault_pkg::REG_STATUS, 32'hB);
		bad <= 1'b1;
		wait_for(1, 40);
		cyc(2);
		check(32'(mod_access_out), 32'hB);
		check(32'(global_io_error_flag_out), 32'h1);
		check(32'(irq_out), 32'h0);
		rd(fault_pkg::REG_IOERR, 32'h4);
		rd(fault_pkg::REG_STATUS, 32'hF);
		rd(fault_pkg::REG_EVENT, 32'h2);
		bad <= 1'b0;
		wait_for(2, 40);
		cyc(2);
		check(32'(global_io_error_flag_out), 32'h0);
		wr(fault_pkg::REG_MASK, 32'hF);
		rnd = lfsr(rnd);
		code = rnd;
		fatal_code_in <= code;
		fatal_detect_in <= 1'b1;
		cyc(1);
		check(32'({ind_out, outputs_out}), 32'h600);
		check(32'(runtime_fault_flag_out), 32'h0);
		cyc(2);
		fatal_detect_in <= 1'b0;
		rd(fault_pkg::REG_LAST, 32'(code));
		rd(fault_pkg::REG_COUNT, 32'h1);
		cyc(30);
		rd(fault_pkg::REG_STATUS, 32'h2);
		check(32'(irq_out), 32'h1);
		rd(fault_pkg::REG_EVENT, 32'h1);
		wr(fault_pkg::REG_CTRL, 32'h2);
		check(32'(ind_out.fault), 32'h0);
		fatal_detect_in <= 1'b1;
		cyc(1);
		fatal_detect_in <= 1'b0;
		check(32'(ind_out.fault), 32'h1);
		rd(fault_pkg::REG_COUNT, 32'h2);
		wr(fault_pkg::REG_CTRL, 32'h2);
		wait_for(0, 500);
		rst_n_in <= 1'b0;
		ram_retained_in <= 1'b1;
		cyc(16);
		rst_n_in <= 1'b1;
		wait_for(0, 500);
		rd(fault_pkg::REG_COUNT, 32'h2);
		rd(fault_pkg::REG_LAST, 32'(code));
		wr(fault_pkg::REG_CTRL, 32'h4);
		rd(fault_pkg::REG_COUNT, 32'h0);
		rd(fault_pkg::REG_LAST, 32'h0);
		mode_sw_in <= fault_pkg::SW_STOP;
		wait_for(3, 10);
		rd(fault_pkg::REG_STATUS, 32'h0);
		cyc(420);
		rd(fault_pkg::REG_STATUS, 32'h1);
		check(32'(outputs_out), 32'h0);
		wr(fault_pkg::REG_CTRL, 32'h1);
		mode_sw_in <= fault_pkg::SW_TERM;
		wait_for(0, 10);
		rd(fault_pkg::REG_STATUS, 32'h3);
		mode_sw_in <= fault_pkg::SW_STOP;
		wait_for(3, 10);
		rd(fault_pkg::REG_STATUS, 32'h0);
		summarize();
	end
endmodule

//--- test/io_modules_model.sv
`timescale 1ns/10ps
module io_modules_model #(
	parameter logic [fault_pkg::NMOD*fault_pkg::CFGW-1:0] CFG = 32'h4433_2211
) (
	// Fault injection
	input  wire logic [1:0]                                 sel_in,
	input  wire logic                                       bad_in,
	// Module status
	output logic      [fault_pkg::NMOD*fault_pkg::CFGW-1:0] cfg_out
);
	// ==========================================
	// Selected module reports a changed configuration
	always_comb begin
		cfg_out = CFG;
		if (bad_in) begin
			cfg_out[sel_in*8 +: 8] = ~CFG[sel_in*8 +: 8];
		end
	end
endmodule
